/* shared/sxd_pkg.sv */
// Package for the swap / xor / direction-load execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package sxd_pkg;
    // Instruction fields
    localparam int OP_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int D_BIT = 7;
    // Opcode patterns and masks
    localparam logic [13:0] SWAP_MASK = 14'h3f00;
    localparam logic [13:0] SWAP_PAT = 14'h0e00;
    localparam logic [13:0] XORF_MASK = 14'h3f00;
    localparam logic [13:0] XORF_PAT = 14'h0600;
    localparam logic [13:0] XORL_MASK = 14'h3f00;
    localparam logic [13:0] XORL_PAT = 14'h3a00;
    localparam logic [13:0] DIR_MASK = 14'h3ff8;
    localparam logic [13:0] DIR_PAT = 14'h0060;
    // Port-direction register range
    localparam logic [2:0] DIR_FIRST = 3'h5;
    localparam logic [2:0] DIR_LAST = 3'h7;
    localparam int DIR_N = 3;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] W_RST = 8'h00;

    typedef enum {SXD_NONE, SXD_SWAP, SXD_XORL, SXD_XORF, SXD_DIR} sxd_op_t;

    // File register access request toward the core's data memory
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } sxd_fwr_t;
endpackage : sxd_pkg

/* rtl/sxd_exec.sv */
// Execute logic for nibble exchange, literal xor, file xor and direction load.
// Assumes the core presents one instruction per cycle with operand already read.
//
// Function
// - nibble_exchange_op swaps upper and lower halves of the addressed register
// - swap result to W when d is 0, to file when 1; flags kept
// - xor_literal_op xors W with the 8-bit literal
// - literal xor result only to W, one instruction word
// - port_direction_load_op copies W to direction register 5 to 7, flags kept
// - direction registers also readable and writable as ordinary registers
// - xor_file_op xors W with file; to W if d is 0, else file; Z updated
`timescale 1ns/1ps
module sxd_exec
    import sxd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Instruction and operand
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rdata,
    // Ordinary register access to direction registers
    input wire logic dir_wr,
    input wire logic [1:0] dir_sel,
    input wire logic [7:0] dir_wdata,
    // Results
    output logic [7:0] w_reg,
    output logic zero_flag,
    output sxd_fwr_t file_wr,
    output logic [23:0] dir_regs,
    output logic [7:0] dir_rdata
);
    sxd_op_t op;
    logic [7:0] result;
    logic dest_file;
    logic [7:0] dir_q [DIR_N];

    // Decode; direction load only for operands 5..7
    always_comb begin
        op = SXD_NONE;
        if (instr_valid) begin
            if ((instr & SWAP_MASK) == SWAP_PAT) op = SXD_SWAP;
            else if ((instr & XORL_MASK) == XORL_PAT) op = SXD_XORL;
            else if ((instr & XORF_MASK) == XORF_PAT) op = SXD_XORF;
            else if ((instr & DIR_MASK) == DIR_PAT && instr[2:0] >= DIR_FIRST)
                op = SXD_DIR;
        end
    end

    assign dest_file = instr[D_BIT];

    // Result path
    always_comb begin
        case (op)
            SXD_SWAP: result = {file_rdata[3:0], file_rdata[7:4]};
            SXD_XORL: result = w_reg ^ instr[7:0];
            SXD_XORF: result = w_reg ^ file_rdata;
            default: result = w_reg;
        endcase
    end

    // Working register; every op finishes in this cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            w_reg <= W_RST;
        end else if (op == SXD_XORL) begin
            w_reg <= result;
        end else if ((op == SXD_SWAP || op == SXD_XORF) && !dest_file) begin
            w_reg <= result;
        end
    end

    // Zero flag only from the xor pair; swap and direction load leave it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_flag <= 1'b0;
        end else if (op == SXD_XORL || op == SXD_XORF) begin
            zero_flag <= (result == 8'h00);
        end
    end

    // File write-back, registered so data outputs come from flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_wr <= '0;
        end else begin
            file_wr.we <= (op == SXD_SWAP || op == SXD_XORF) && dest_file;
            file_wr.addr <= instr[6:0];
            file_wr.data <= result;
        end
    end

    // Direction registers: opcode load or plain register write
    genvar g;
    generate
        for (g = 0; g < DIR_N; g++) begin : g_dir
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    dir_q[g] <= DIR_RST;
                end else if (op == SXD_DIR && instr[1:0] == 2'(g + 1)) begin
                    dir_q[g] <= w_reg;
                end else if (dir_wr && dir_sel == 2'(g)) begin
                    dir_q[g] <= dir_wdata;
                end
            end
            assign dir_regs[g*8 +: 8] = dir_q[g];
        end
    endgenerate

    // Readback; index 3 unmapped reads zero
    assign dir_rdata = (dir_sel < 2'(DIR_N)) ? dir_q[dir_sel] : 8'h00;

    // Checks
    swap_to_w_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_SWAP && !dest_file |=> w_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap result not in W");
    swap_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_SWAP |=> $stable(zero_flag))
        else $error("swap changed zero flag");
    swap_file_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_SWAP && dest_file |=> file_wr.we && $stable(w_reg))
        else $error("swap file write missing");
    xorl_w_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_XORL |=> w_reg == ($past(w_reg) ^ $past(instr[7:0])) && !file_wr.we)
        else $error("literal xor wrong");
    xorf_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_XORF |=> zero_flag == ($past(w_reg) == $past(file_rdata)))
        else $error("zero flag wrong");
    xorf_file_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_XORF && dest_file |=> file_wr.data == ($past(w_reg) ^ $past(file_rdata)))
        else $error("file xor data wrong");
    xorl_once_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_XORL ##1 op == SXD_NONE |=> $stable(w_reg))
        else $error("W changed after literal xor");
    dir_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_DIR && instr[1:0] == 2'h1
        |=> dir_regs[7:0] == $past(w_reg) && $stable(zero_flag))
        else $error("direction load wrong");
    dir_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        dir_wr && dir_sel == 2'h2 && op != SXD_DIR |=> dir_regs[23:16] == $past(dir_wdata))
        else $error("direction write lost");

    // Literal xor must refresh the zero flag from its own result
    xorl_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_XORL |=> zero_flag == (($past(w_reg) ^ $past(instr[7:0])) == 8'h00))
        else $error("literal xor zero flag wrong");

    // File xor to W leaves the data memory alone
    xorf_w_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_XORF && !dest_file |=> w_reg == ($past(w_reg) ^ $past(file_rdata)) && !file_wr.we)
        else $error("file xor to W wrong");

    // File xor to the register keeps W and targets the operand address
    xorf_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_XORF && dest_file |=> $stable(w_reg) && file_wr.we && file_wr.addr == $past(instr[6:0]))
        else $error("file xor write-back wrong");

    // Swapped value on the write-back path
    swap_data_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_SWAP && dest_file |=> file_wr.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap write-back data wrong");

    // Swap into W must not also write the file
    swap_nowrite_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_SWAP && !dest_file |=> !file_wr.we)
        else $error("swap to W wrote the file");

    // Swap write-back goes to the operand address
    swap_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_SWAP && dest_file |=> file_wr.addr == $past(instr[6:0]))
        else $error("swap write-back address wrong");

    // Direction load touches neither W, flags nor data memory
    dir_keep_w_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_DIR |=> $stable(w_reg) && $stable(zero_flag) && !file_wr.we)
        else $error("direction load disturbed core state");

    // Operands below five are not direction registers
    dir_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && (instr & DIR_MASK) == DIR_PAT && instr[2:0] < DIR_FIRST |-> op == SXD_NONE)
        else $error("direction load below range decoded");

    // Middle direction register load
    dir_mid_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_DIR && instr[1:0] == 2'h2 |=> dir_regs[15:8] == $past(w_reg))
        else $error("middle direction load wrong");

    // Top register load; also wins over a plain write in the same cycle
    dir_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        op == SXD_DIR && instr[1:0] == 2'h3 |=> dir_regs[23:16] == $past(w_reg))
        else $error("top direction load wrong");

    // Readback mirrors the selected register
    dir_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        dir_sel != 2'h3 |-> dir_rdata == dir_regs[8*dir_sel +: 8])
        else $error("direction readback wrong");

    // Unmapped select reads zero, never stale data
    dir_unmapped_a: assert property (@(posedge clk) disable iff (sys_rst)
        dir_sel == 2'h3 |-> dir_rdata == 8'h00)
        else $error("unmapped readback not zero");

    // Plain write to the lowest register
    dir_write_lo_a: assert property (@(posedge clk) disable iff (sys_rst)
        dir_wr && dir_sel == 2'h0 && op != SXD_DIR |=> dir_regs[7:0] == $past(dir_wdata))
        else $error("low direction write lost");

    // Without a write source the direction registers hold
    dir_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        !dir_wr && op != SXD_DIR |=> $stable(dir_regs))
        else $error("direction register changed idle");

    // No instruction: W and zero flag hold and file write enable is low; each op lives one cycle only
    idle_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !instr_valid |=> $stable(w_reg) && $stable(zero_flag) && !file_wr.we)
        else $error("state changed without instruction");

    // Decode of the nibble exchange pattern
    dec_swap_a: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && (instr & SWAP_MASK) == SWAP_PAT |-> op == SXD_SWAP)
        else $error("swap not decoded");

    // Decode of the literal xor pattern
    dec_xorl_a: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && (instr & XORL_MASK) == XORL_PAT |-> op == SXD_XORL)
        else $error("literal xor not decoded");

    // Decode of the file xor pattern
    dec_xorf_a: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && (instr & XORF_MASK) == XORF_PAT |-> op == SXD_XORF)
        else $error("file xor not decoded");
endmodule : sxd_exec

/* tb/tb_top.sv */
// Self-checking bench for the swap / xor / direction-load execute block.
// Assumes one instruction per cycle and results visible one cycle later.
`timescale 1ns/1ps
module tb_top;
    import sxd_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, dir_wr = 1'b0;
    logic [13:0] instr = 14'h0;
    logic [7:0] file_rdata = 8'h0, dir_wdata = 8'h0, w_reg, dir_rdata;
    logic [1:0] dir_sel = 2'h0;
    logic zero_flag;
    sxd_fwr_t file_wr;
    logic [23:0] dir_regs;
    int num_errors = 0, check_count = 0;
    // Free-running 40 MHz clock
    always #12.5 clk = ~clk;
    sxd_exec dut_u (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr(instr), .file_rdata(file_rdata), .dir_wr(dir_wr), .dir_sel(dir_sel),
        .dir_wdata(dir_wdata), .w_reg(w_reg), .zero_flag(zero_flag),
        .file_wr(file_wr), .dir_regs(dir_regs), .dir_rdata(dir_rdata));
    // Four-state compare, so an unknown never matches
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One instruction; returns just after its result lands
    task automatic exec(input logic [13:0] op, input logic [7:0] fv);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= op;
        file_rdata <= fv;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask : exec
    task automatic t_xorl;
        exec(14'h3ab5, 8'h00);
        chk("w", w_reg, 8'hb5);
        chk("z", zero_flag, 1'b0);
        exec(14'h3ab5, 8'h00);
        chk("w", w_reg, 8'h00);
        chk("z", zero_flag, 1'b1);
        chk("we", file_wr.we, 1'b0);
        $display("test xorl done");
    endtask : t_xorl
    // Z is left at 1 on entry, so any flag change shows
    task automatic t_swap;
        exec(14'h0e85, 8'ha5);
        chk("fwr", file_wr, {1'b1, 7'h05, 8'h5a});
        chk("w", w_reg, 8'h00);
        exec(14'h0e05, 8'h3c);
        chk("w", w_reg, 8'hc3);
        chk("z", zero_flag, 1'b1);
        $display("test swap done");
    endtask : t_swap
    task automatic t_xorf;
        exec(14'h06d0, 8'hc3);
        chk("fwr", file_wr, {1'b1, 7'h50, 8'h00});
        exec(14'h0650, 8'h0f);
        chk("w", w_reg, 8'hcc);
        chk("z", zero_flag, 1'b0);
        $display("test xorf done");
    endtask : t_xorf
    // Loads reg 6, then f=4 must be ignored
    task automatic t_dir;
        exec(14'h0066, 8'h00);
        chk("dir", dir_regs, {8'hff, 8'hcc, 8'hff});
        exec(14'h0064, 8'h00);
        chk("dir", dir_regs, {8'hff, 8'hcc, 8'hff});
        chk("z", zero_flag, 1'b0);
        @(posedge clk);
        dir_wr <= 1'b1;
        dir_sel <= 2'h2;
        dir_wdata <= 8'h3c;
        @(posedge clk);
        dir_wr <= 1'b0;
        #1;
        chk("dir", dir_regs[23:16], 8'h3c);
        chk("rd", dir_rdata, 8'h3c);
        @(posedge clk);
        dir_sel <= 2'h3;
        @(posedge clk);
        #1;
        chk("rd", dir_rdata, 8'h00);
        $display("test dir done");
    endtask : t_dir
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("dir", dir_regs, 24'hffffff);
        chk("w", w_reg, 8'h00);
        chk("z", zero_flag, 1'b0);
        chk("fwr", file_wr, 16'h0000);
        t_xorl;
        t_swap;
        t_xorf;
        t_dir;
        summarize;
    end
    // Watchdog, far beyond the few dozen cycles needed
    initial begin
        #20000;
        num_errors++;
        summarize;
    end
endmodule : tb_top
